/* logic/rx_alarm_irq.sv */
// receive out-of-frame and alarm-signal interrupt logic, one channel
// assumes line events come from framer logic on the same clock
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module rx_alarm_irq
  import rx_alarm_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // register port
  input wire rx_alarm_pkg::reg_req_t i_req,
  output logic [7:0] o_rdata,
  // line events
  input wire rx_alarm_pkg::line_evt_t i_evt,
  // alarm outputs
  output logic o_irq_n,
  output logic o_far_fail
);
  import rx_alarm_pkg::*;

  alarm_state_t s_q;
  alarm_state_t s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] count_ones(input logic [FBIT_WINDOW-1:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int k = 0; k < FBIT_WINDOW; k++)
    begin
      n = n + {4'h0, v[k]};
    end
    return n;
  endfunction

  logic [FBIT_WINDOW-1:0] hist_next;
  logic [4:0] err_count;
  logic [4:0] err_limit;
  logic rd_flags;
  logic [7:0] set_mask;
  logic [7:0] clr_mask;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    hist_next = s_q.hist;
    if (i_evt.fbit_valid)
    begin
      hist_next = {s_q.hist[FBIT_WINDOW-2:0], i_evt.fbit_err};
    end
    s_d.hist = hist_next;
    err_count = count_ones(hist_next);
    err_limit = s_q.thr_hi ? FBIT_ERR_HI : FBIT_ERR_LO;

    // frame-loss declare and clear
    if (!s_q.oof && err_count >= err_limit)
    begin
      s_d.oof = 1'b1;
    end
    else if (s_q.oof && i_evt.infr_enter)
    begin
      s_d.oof = 1'b0;
      s_d.hist = '0;
    end

    // alarm-signal persistence counter
    if (i_evt.frame_end)
    begin
      if (i_evt.frame_ais != s_q.ais)
      begin
        if (s_q.ais_cnt == ALARM_FRAMES - 6'h01)
        begin
          s_d.ais = i_evt.frame_ais;
          s_d.ais_cnt = 6'h00;
        end
        else
        begin
          s_d.ais_cnt = s_q.ais_cnt + 6'h01;
        end
      end
      else
      begin
        s_d.ais_cnt = 6'h00;
      end
    end

    // sticky flags, set wins over read clear
    set_mask = 8'h00;
    set_mask[FLAG_FRAME_LOSS] = (s_d.oof != s_q.oof) && s_q.en[FLAG_FRAME_LOSS];
    set_mask[FLAG_ALARM_SIGNAL] = (s_d.ais != s_q.ais) && s_q.en[FLAG_ALARM_SIGNAL];
    rd_flags = i_req.rd && i_req.addr == ADDR_IRQ_FLAGS;
    clr_mask = rd_flags ? s_q.flags : 8'h00;
    s_d.flags = (s_q.flags & ~clr_mask) | set_mask;

    // register writes
    if (i_req.wr)
    begin
      unique case (i_req.addr)
        ADDR_IRQ_ENABLE:
        begin
          s_d.en = i_req.wdata;
        end
        ADDR_LINE_CTRL:
        begin
          s_d.thr_hi = i_req.wdata[CTRL_THRESH_HI];
        end
        default:
        begin
          s_d.en = s_q.en;
        end
      endcase
    end

    // register reads, data stand one cycle later
    s_d.rdata = 8'h00;
    if (i_req.rd)
    begin
      unique case (i_req.addr)
        ADDR_ALARM_STATE:
        begin
          s_d.rdata[LIVE_FRAME_LOSS] = s_q.oof;
          s_d.rdata[LIVE_ALARM_SIGNAL] = s_q.ais;
        end
        ADDR_IRQ_ENABLE:
        begin
          s_d.rdata = s_q.en;
        end
        ADDR_IRQ_FLAGS:
        begin
          s_d.rdata = s_q.flags;
        end
        ADDR_LINE_CTRL:
        begin
          s_d.rdata[CTRL_THRESH_HI] = s_q.thr_hi;
        end
        default:
        begin
          s_d.rdata = 8'h00;
        end
      endcase
    end

    // outputs
    s_d.irq_n = ~|(s_d.flags & s_d.en);
    s_d.far_fail = s_d.oof | s_d.ais;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_q <= '{hist: '0, oof: 1'b0, ais: 1'b0, ais_cnt: 6'h00, en: REG_RESET,
               flags: REG_RESET, thr_hi: 1'b0, irq_n: 1'b1, far_fail: 1'b0,
               rdata: 8'h00};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_irq_n = s_q.irq_n;
  assign o_far_fail = s_q.far_fail;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  irq_request_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (|(s_q.flags & s_q.en)) |-> !o_irq_n)
    else $error("enabled flag set but request not low");

  irq_release_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (s_q.flags & s_q.en) == 8'h00 |-> o_irq_n)
    else $error("request low with no enabled flag");

  loss_flag_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (s_q.oof != $past(s_q.oof)) && $past(s_q.en[FLAG_FRAME_LOSS])
      |-> s_q.flags[FLAG_FRAME_LOSS])
    else $error("frame-loss change did not set its flag");

  alarm_flag_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (s_q.ais != $past(s_q.ais)) && $past(s_q.en[FLAG_ALARM_SIGNAL])
      |-> s_q.flags[FLAG_ALARM_SIGNAL])
    else $error("alarm-signal change did not set its flag");

  masked_no_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !$past(s_q.en[FLAG_ALARM_SIGNAL]) && !$past(s_q.flags[FLAG_ALARM_SIGNAL])
      |-> !s_q.flags[FLAG_ALARM_SIGNAL])
    else $error("alarm flag latched while disabled");

  live_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_req.rd && i_req.addr == ADDR_ALARM_STATE
      |=> o_rdata[LIVE_FRAME_LOSS] == $past(s_q.oof)
          && o_rdata[LIVE_ALARM_SIGNAL] == $past(s_q.ais))
    else $error("live state read wrong");

  alarm_declare_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(s_q.ais) |-> $past(s_q.ais_cnt) == ALARM_FRAMES - 6'h01 && $past(i_evt.frame_ais))
    else $error("alarm declared without 63 frames");

  alarm_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(s_q.ais) |-> $past(s_q.ais_cnt) == ALARM_FRAMES - 6'h01 && !$past(i_evt.frame_ais))
    else $error("alarm cleared without 63 frames");

  loss_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(s_q.oof) |-> $past(i_evt.infr_enter))
    else $error("frame loss cleared without in-frame entry");

  far_fail_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_far_fail == (s_q.oof || s_q.ais))
    else $error("far-end failure indicator mismatch");

  read_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_req.rd && i_req.addr == ADDR_IRQ_FLAGS)
      ##1 (s_q.oof == $past(s_q.oof) && s_q.ais == $past(s_q.ais))
      |-> s_q.flags == 8'h00)
    else $error("flags not cleared by read");

  rdata_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !$past(i_req.rd) |-> o_rdata == 8'h00)
    else $error("read data stood outside its cycle");

  flag_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_req.rd && i_req.addr == ADDR_IRQ_FLAGS |=> o_rdata == $past(s_q.flags))
    else $error("flag read returned wrong data");

  flag_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !(i_req.rd && i_req.addr == ADDR_IRQ_FLAGS)
      |=> (s_q.flags & $past(s_q.flags)) == $past(s_q.flags))
    else $error("flag cleared without a read");

  loss_masked_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !$past(s_q.en[FLAG_FRAME_LOSS]) && !$past(s_q.flags[FLAG_FRAME_LOSS])
      |-> !s_q.flags[FLAG_FRAME_LOSS])
    else $error("frame-loss flag latched while disabled");

  loss_declare_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(s_q.oof)
      |-> count_ones(s_q.hist) >= ($past(s_q.thr_hi) ? FBIT_ERR_HI : FBIT_ERR_LO))
    else $error("frame loss declared below the error limit");

  loss_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_q.oof && !i_evt.infr_enter |=> s_q.oof)
    else $error("frame loss left without in-frame entry");

  loss_irq_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (s_q.oof != $past(s_q.oof)) && $past(s_q.en[FLAG_FRAME_LOSS])
      && s_q.en[FLAG_FRAME_LOSS] |-> !o_irq_n)
    else $error("frame-loss change did not raise the request");

  alarm_irq_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (s_q.ais != $past(s_q.ais)) && $past(s_q.en[FLAG_ALARM_SIGNAL])
      && s_q.en[FLAG_ALARM_SIGNAL] |-> !o_irq_n)
    else $error("alarm-signal change did not raise the request");

  alarm_stable_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_evt.frame_end |=> $stable(s_q.ais) && $stable(s_q.ais_cnt))
    else $error("alarm state moved without a frame");

  alarm_count_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_evt.frame_end && (i_evt.frame_ais == s_q.ais) |=> s_q.ais_cnt == 6'h00)
    else $error("alarm count not restarted by a matching frame");

  enable_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_req.wr && i_req.addr == ADDR_IRQ_ENABLE |=> s_q.en == $past(i_req.wdata))
    else $error("enable write not stored");

  thr_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_req.wr && i_req.addr == ADDR_LINE_CTRL
      |=> s_q.thr_hi == $past(i_req.wdata[CTRL_THRESH_HI]))
    else $error("threshold select not stored");

  far_fail_alarm_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_q.ais |-> o_far_fail)
    else $error("alarm signal without far-end failure indicator");

endmodule

`default_nettype wire

/* logic/rx_alarm_pkg.sv */
// shared constants and carriers for the receive alarm interrupt block
// assumes a single 100 MHz clock and an 8-bit register port
package rx_alarm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ALARM_STATE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h12;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h13;
  localparam logic [7:0] ADDR_LINE_CTRL = 8'h14;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int FLAG_FRAME_LOSS = 1;
  localparam int FLAG_ALARM_SIGNAL = 5;
  localparam int LIVE_FRAME_LOSS = 4;
  localparam int LIVE_ALARM_SIGNAL = 7;
  localparam int CTRL_THRESH_HI = 0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // detector figures
  // ----------------------------------------------------------------
  localparam int FBIT_WINDOW = 16;
  localparam logic [4:0] FBIT_ERR_LO = 5'h03;
  localparam logic [4:0] FBIT_ERR_HI = 5'h06;
  localparam logic [5:0] ALARM_FRAMES = 6'h3F;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic fbit_valid;
    logic fbit_err;
    logic frame_end;
    logic frame_ais;
    logic infr_enter;
  } line_evt_t;

  typedef struct packed {
    logic [FBIT_WINDOW-1:0] hist;
    logic oof;
    logic ais;
    logic [5:0] ais_cnt;
    logic [7:0] en;
    logic [7:0] flags;
    logic thr_hi;
    logic irq_n;
    logic far_fail;
    logic [7:0] rdata;
  } alarm_state_t;

endpackage

/* verification/rx_alarm_host.sv */
// host model: register access and interrupt servicing
// assumes read data stand in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

module rx_alarm_host
(
  // clock
  input wire logic i_clk,
  // register port
  output var rx_alarm_pkg::reg_req_t o_req,
  input wire logic [7:0] i_rdata
);
  import rx_alarm_pkg::*;

  logic [7:0] flags_seen;
  logic [7:0] state_seen;
  logic feac_present;

  initial o_req = '0;

  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    o_req <= '0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    o_req <= '0;
    @(posedge i_clk);
    d = i_rdata;
  endtask

  // flags first, then live state for the far-end report
  task automatic service();
    rd(ADDR_IRQ_FLAGS, flags_seen);
    rd(ADDR_ALARM_STATE, state_seen);
    feac_present = |(state_seen & 8'h90);
  endtask
endmodule

`default_nettype wire

/* verification/testbench.sv */
// testbench for the receive alarm interrupt block
// assumes the host model owns the register port
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import rx_alarm_pkg::*;

  localparam line_evt_t ERR = 5'h18;
  localparam line_evt_t AISF = 5'h06;
  localparam line_evt_t CLNF = 5'h04;
  localparam line_evt_t INFR = 5'h01;
  logic i_clk;
  logic i_resetn;
  line_evt_t evt;
  reg_req_t req;
  logic [7:0] rdata;
  logic irq_n;
  logic far_fail;
  logic [7:0] pins;
  logic [7:0] v;
  logic [7:0] addrs [5];
  int errors;
  int checks;
  int cyc;

  // pins bit1 request line, bit0 far-end failure
  assign pins = {6'h00, irq_n, far_fail};

  rx_alarm_irq dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(req), .o_rdata(rdata),
    .i_evt(evt), .o_irq_n(irq_n), .o_far_fail(far_fail));
  rx_alarm_host host (.i_clk(i_clk), .o_req(req), .i_rdata(rdata));

  // ------------------------------------------------------------
  // clock, timeout and helpers
  // ------------------------------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errors++;
      results();
    end
  end

  task automatic results();
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ev(input line_evt_t e, input int n);
    repeat (n)
    begin
      evt <= e;
      @(posedge i_clk);
      evt <= '0;
      @(posedge i_clk);
    end
  endtask

  task automatic svc(input logic [7:0] f, input logic [7:0] s);
    host.service();
    chk(host.flags_seen, f);
    chk(host.state_seen, s);
    chk({7'h00, host.feac_present}, {7'h00, s != 8'h00});
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    i_resetn = 1'b0;
    evt = '0;
    errors = 0;
    checks = 0;
    cyc = 0;
    addrs = '{ADDR_ALARM_STATE, ADDR_IRQ_ENABLE, ADDR_IRQ_FLAGS, ADDR_LINE_CTRL, 8'h20};
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    chk(pins, 8'h02);
    foreach (addrs[i])
    begin
      host.rd(addrs[i], v);
      chk(v, REG_RESET);
    end
    host.wr(ADDR_IRQ_ENABLE, 8'hA5);
    host.rd(ADDR_IRQ_ENABLE, v);
    chk(v, 8'hA5);
    host.wr(ADDR_ALARM_STATE, 8'hFF);
    host.wr(8'h20, 8'hFF);
    host.rd(ADDR_ALARM_STATE, v);
    chk(v, 8'h00);
    host.wr(ADDR_IRQ_ENABLE, 8'h22);
    ev(ERR, 2);
    chk(pins, 8'h02);
    ev(ERR, 1);
    chk(pins, 8'h01);
    svc(8'h02, 8'h10);
    chk(pins, 8'h03);
    svc(8'h00, 8'h10);
    ev(INFR, 1);
    chk(pins, 8'h00);
    svc(8'h02, 8'h00);
    host.wr(ADDR_LINE_CTRL, 8'h01);
    ev(ERR, 5);
    chk(pins, 8'h02);
    ev(ERR, 1);
    chk(pins, 8'h01);
    ev(INFR, 1);
    svc(8'h02, 8'h00);
    ev(AISF, 62);
    chk(pins, 8'h02);
    ev(AISF, 1);
    chk(pins, 8'h01);
    svc(8'h20, 8'h80);
    ev(CLNF, 62);
    chk(pins, 8'h03);
    ev(CLNF, 1);
    chk(pins, 8'h00);
    svc(8'h20, 8'h00);
    host.wr(ADDR_IRQ_ENABLE, 8'h00);
    ev(ERR, 6);
    chk(pins, 8'h03);
    svc(8'h00, 8'h10);
    ev(INFR, 1);
    ev(AISF, 63);
    chk(pins, 8'h03);
    svc(8'h00, 8'h80);
    results();
  end
endmodule

`default_nettype wire
